//--- hw/octal_character_load_packer.sv
// Purpose: hardware load path packing octal characters from the I/O bus into 12-bit memory words
// Assumes: aclk 100 MHz; character pins asynchronous to aclk; strobe period at least 10 us
// Notes:   registers over AXI4-Lite; memory written through a registered write port
`timescale 1ns/100ps

module octal_character_load_packer #(
    parameter int unsigned ADDR_W = load_packer_pkg::AXI_ADDR_W
) (
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    input  wire logic                           clk_en,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]              s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [ADDR_W-1:0]              s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    // load mode pins, 1 = line at ground
    input  wire logic                           char_bit_low,
    input  wire logic                           char_bit_mid,
    input  wire logic                           char_bit_high,
    input  wire logic                           delete_char_in,
    input  wire logic                           zero_marker_in,
    input  wire logic                           stop_command_in,
    input  wire logic                           char_strobe_in,
    input  wire logic                           unused_bus_bit6,
    input  wire logic                           unused_bus_bit8,
    input  wire logic                           unused_bus_bit10,
    input  wire logic                           unused_bus_bit11,
    input  wire logic                           unused_bus_bit12,
    output logic                                load_active_out,
    // memory write port
    output load_packer_pkg::mem_write_type      mem_write
);

    typedef struct packed {
        load_packer_pkg::char_bus_type          sync1;
        load_packer_pkg::char_bus_type          sync2;
        logic                                   strobe_prev;
        logic                                   active;
        logic                                   load_sw;
        logic [load_packer_pkg::WORD_W-1:0]     acc;
        logic [1:0]                             cnt;
        logic [load_packer_pkg::PC_W-1:0]       pc;
        load_packer_pkg::mem_write_type         mem;
        logic                                   aw_held;
        logic [ADDR_W-1:0]                      aw_addr;
        logic                                   w_held;
        logic [31:0]                            w_data;
        logic [3:0]                             w_strb;
        logic                                   awready;
        logic                                   wready;
        logic                                   bvalid;
        logic [1:0]                             bresp;
        logic                                   arready;
        logic                                   rvalid;
        logic [31:0]                            rdata;
        logic [1:0]                             rresp;
    } state_type;

    state_type                                  state;
    state_type                                  next_state;
    load_packer_pkg::char_bus_type              pins;
    logic                                       strobe_rise;
    logic                                       char_valid;
    logic [31:0]                                wmask;
    logic [31:0]                                wval;
    logic [7:0]                                 waddr;
    logic [7:0]                                 raddr;

    // bit weights of the octal character
    assign pins.data        = {char_bit_high, char_bit_mid, char_bit_low};
    assign pins.delete_char = delete_char_in;
    assign pins.zero_marker = zero_marker_in;
    assign pins.stop        = stop_command_in;
    assign pins.strobe      = char_strobe_in;

    // strobe going passive to ground (0 to 1), synchronised copy only
    assign strobe_rise = !state.strobe_prev && state.sync2.strobe;
    // blank, leader and deleted characters are not data
    assign char_valid  = !state.sync2.delete_char &&
                         ((state.sync2.data != 3'h0) || state.sync2.zero_marker);

    always_comb begin
        next_state         = state;
        wmask              = {{8{state.w_strb[3]}}, {8{state.w_strb[2]}},
                              {8{state.w_strb[1]}}, {8{state.w_strb[0]}}};
        wval               = state.w_data & wmask;
        waddr              = 8'(state.aw_addr);
        raddr              = 8'(s_axi_araddr);

        // pins cross into aclk through two flops
        next_state.sync1       = pins;
        next_state.sync2       = state.sync1;
        next_state.strobe_prev = state.sync2.strobe;
        next_state.mem.en      = 1'b0;

        // stop acts on its level alone, other bits ignored
        if (state.active && state.sync2.stop) begin
            next_state.active = 1'b0;
        // only accepted characters touch memory, all writes inbound
        end else if (state.active && strobe_rise && char_valid) begin
            // shift old digits down, new one enters at the top
            if (state.cnt == load_packer_pkg::CNT_RESET) begin
                next_state.acc = {state.sync2.data, 9'h000};
            end else begin
                next_state.acc = {state.sync2.data, state.acc[load_packer_pkg::WORD_W-1:load_packer_pkg::CHAR_W]};
            end
            // store the partial word at the current address
            next_state.mem.en   = 1'b1;
            next_state.mem.addr = state.pc;
            next_state.mem.data = next_state.acc;
            // step address after the fourth character
            if (state.cnt == load_packer_pkg::LAST_CHAR) begin
                next_state.cnt = load_packer_pkg::CNT_RESET;
                next_state.pc  = state.pc + 12'h001;
            end else begin
                next_state.cnt = state.cnt + 2'h1;
            end
        end

        // write channel: address and data may come in either order
        if (s_axi_awvalid && state.awready) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state.wready) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        if (state.aw_held && state.w_held && !state.bvalid) begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = load_packer_pkg::RESP_OKAY;
            unique case (waddr)
                load_packer_pkg::CTRL_OFFSET: begin
                    if (state.w_strb[0]) begin
                        next_state.load_sw = state.w_data[load_packer_pkg::CTRL_LOAD_BIT];
                        // load and start together begin at the held address
                        if (state.w_data[load_packer_pkg::CTRL_LOAD_BIT] &&
                            state.w_data[load_packer_pkg::CTRL_START_BIT] && !state.active) begin
                            next_state.active = 1'b1;
                            next_state.cnt    = load_packer_pkg::CNT_RESET;
                        end
                        if (state.w_data[load_packer_pkg::CTRL_STOP_BIT]) begin
                            next_state.active = 1'b0;
                        end
                    end
                end
                load_packer_pkg::PC_OFFSET: begin
                    // address is owned by the loader while it runs
                    if (!state.active) begin
                        next_state.pc = (state.pc & ~wmask[load_packer_pkg::PC_W-1:0]) |
                                        wval[load_packer_pkg::PC_W-1:0];
                    end
                end
                load_packer_pkg::STAT_OFFSET,
                load_packer_pkg::ACC_OFFSET: begin
                end
                default: begin
                    next_state.bresp = load_packer_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_state.awready = !next_state.aw_held && !next_state.bvalid;
        next_state.wready  = !next_state.w_held && !next_state.bvalid;

        // read channel
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        if (s_axi_arvalid && state.arready) begin
            next_state.rvalid = 1'b1;
            next_state.rresp  = load_packer_pkg::RESP_OKAY;
            next_state.rdata  = 32'h0000_0000;
            unique case (raddr)
                load_packer_pkg::CTRL_OFFSET: begin
                    next_state.rdata[load_packer_pkg::CTRL_LOAD_BIT] = state.load_sw;
                end
                load_packer_pkg::PC_OFFSET: begin
                    next_state.rdata[load_packer_pkg::PC_W-1:0] = state.pc;
                end
                load_packer_pkg::STAT_OFFSET: begin
                    next_state.rdata[load_packer_pkg::STAT_ACTIVE_BIT] = state.active;
                    next_state.rdata[load_packer_pkg::STAT_CNT_LSB +: 2] = state.cnt;
                end
                load_packer_pkg::ACC_OFFSET: begin
                    next_state.rdata[load_packer_pkg::WORD_W-1:0] = state.acc;
                end
                default: begin
                    next_state.rresp = load_packer_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_state.arready = !next_state.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state          <= '0;
            state.pc       <= load_packer_pkg::PC_RESET;
            state.acc      <= load_packer_pkg::ACC_RESET;
            state.cnt      <= load_packer_pkg::CNT_RESET;
        end else if (clk_en) begin
            state          <= next_state;
        end
    end

    // reader is commanded by this level
    assign load_active_out = state.active;
    assign mem_write       = state.mem;
    assign s_axi_awready   = state.awready;
    assign s_axi_wready    = state.wready;
    assign s_axi_bvalid    = state.bvalid;
    assign s_axi_bresp     = state.bresp;
    assign s_axi_arready   = state.arready;
    assign s_axi_rvalid    = state.rvalid;
    assign s_axi_rdata     = state.rdata;
    assign s_axi_rresp     = state.rresp;

    // bits six, eight, ten, eleven, twelve feed nothing; stop path likewise skips data

endmodule // octal_character_load_packer

//--- pkg/load_packer_pkg.sv
// Purpose: shared constants and carrier types for the octal character load packer
// Assumes: AXI4-Lite register access with 32-bit data, byte addresses
// Notes:   pin levels are given as logic values, 1 meaning the line is at ground
package load_packer_pkg;

    localparam int unsigned        AXI_ADDR_W   = 8;
    localparam int unsigned        PC_W         = 12;
    localparam int unsigned        WORD_W       = 12;
    localparam int unsigned        CHAR_W       = 3;
    localparam int unsigned        CHARS_PER_WD = 4;

    // register byte offsets
    localparam logic [7:0]         CTRL_OFFSET  = 8'h00;
    localparam logic [7:0]         PC_OFFSET    = 8'h04;
    localparam logic [7:0]         STAT_OFFSET  = 8'h08;
    localparam logic [7:0]         ACC_OFFSET   = 8'h0C;

    // control register fields
    localparam int unsigned        CTRL_LOAD_BIT  = 0;
    localparam int unsigned        CTRL_START_BIT = 1;
    localparam int unsigned        CTRL_STOP_BIT  = 2;
    // status register fields
    localparam int unsigned        STAT_ACTIVE_BIT = 0;
    localparam int unsigned        STAT_CNT_LSB    = 4;

    // reset values and last character count
    localparam logic [PC_W-1:0]    PC_RESET     = 12'h000;
    localparam logic [WORD_W-1:0]  ACC_RESET    = 12'h000;
    localparam logic [1:0]         CNT_RESET    = 2'h0;
    localparam logic [1:0]         LAST_CHAR    = 2'h3;

    localparam logic [1:0]         RESP_OKAY    = 2'h0;
    localparam logic [1:0]         RESP_SLVERR  = 2'h2;

    // shortest strobe period the sender is allowed to use
    localparam real                STROBE_MIN_PERIOD_US = 10.0;

    // octal character bus as seen after synchronisation
    typedef struct packed {
        logic                strobe;
        logic                stop;
        logic                zero_marker;
        logic                delete_char;
        logic [CHAR_W-1:0]   data;
    } char_bus_type;

    // memory write port carrying the packed word
    typedef struct packed {
        logic                en;
        logic [PC_W-1:0]     addr;
        logic [WORD_W-1:0]   data;
    } mem_write_type;

endpackage

//--- dv/load_packer_monitor.sv
// Purpose: port-level checks of the octal character load packer
// Assumes: synchronous active-low reset; clk_en low freezes all state
// Notes:   helper flops remember the previous memory write of the session
`timescale 1ns/100ps
module load_packer_monitor (
    input wire logic                           aclk,
    input wire logic                           aresetn,
    input wire logic                           clk_en,
    input wire logic                           char_bit_low,
    input wire logic                           char_bit_mid,
    input wire logic                           char_bit_high,
    input wire logic                           delete_char_in,
    input wire logic                           zero_marker_in,
    input wire logic                           stop_command_in,
    input wire logic                           char_strobe_in,
    input wire logic                           load_active_out,
    input wire load_packer_pkg::mem_write_type mem_write
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn || !clk_en);
    logic        seen;
    logic        first;
    logic [1:0]  pos;
    logic [11:0] prev_addr;
    logic [11:0] prev_data;
    // a new session or a full word makes the next write the first of a word
    assign first = !seen || pos == 2'h3;
    always_ff @(posedge aclk) begin
        if (!aresetn || !load_active_out) begin
            seen <= 1'b0;
            pos  <= 2'h0;
        end else if (clk_en && mem_write.en) begin
            seen      <= 1'b1;
            pos       <= first ? 2'h0 : pos + 2'h1;
            prev_addr <= mem_write.addr;
            prev_data <= mem_write.data;
        end
    end
    property p_stop_ends; stop_command_in [*6] |=> !load_active_out; endproperty
    a_stop_ends: assert property (p_stop_ends)
        else $error("load stayed active under a held stop");
    property p_write_in_load; mem_write.en |-> $past(load_active_out); endproperty
    a_write_in_load: assert property (p_write_in_load)
        else $error("memory write outside load mode");
    property p_top_char;
        mem_write.en |-> char_strobe_in && mem_write.data[11:9] == {char_bit_high, char_bit_mid, char_bit_low};
    endproperty
    a_top_char: assert property (p_top_char)
        else $error("top digit differs from the character lines");
    property p_no_delete; mem_write.en |-> !delete_char_in; endproperty
    a_no_delete: assert property (p_no_delete)
        else $error("deleted character was stored");
    property p_zero_mark; mem_write.en && mem_write.data[11:9] == 3'h0 |-> zero_marker_in; endproperty
    a_zero_mark: assert property (p_zero_mark)
        else $error("blank character was stored");
    property p_one_write; mem_write.en |=> !mem_write.en; endproperty
    a_one_write: assert property (p_one_write)
        else $error("more than one write for a character");
    property p_shift;
        mem_write.en && !first |-> mem_write.data[8:0] == prev_data[11:3] && mem_write.addr == prev_addr;
    endproperty
    a_shift: assert property (p_shift)
        else $error("accumulator not shifted by one digit");
    property p_next_word;
        mem_write.en && first |-> mem_write.data[8:0] == 9'h000 && (!seen || mem_write.addr == prev_addr + 12'h001);
    endproperty
    a_next_word: assert property (p_next_word)
        else $error("word address did not step after four characters");
endmodule // load_packer_monitor

bind octal_character_load_packer load_packer_monitor u_mon (.aclk, .aresetn, .clk_en, .char_bit_low,
    .char_bit_mid, .char_bit_high, .delete_char_in, .zero_marker_in, .stop_command_in, .char_strobe_in,
    .load_active_out, .mem_write);

//--- dv/tape_reader_model.sv
// Purpose: behavioural character reader on the load mode pins
// Assumes: pull-ups on the lines, so a released line reads as zero
// Notes:   strobe rests passive (0) and pulses to ground (1) to mark a character
`timescale 1ns/100ps
module tape_reader_model (
    input wire logic  aclk,
    output logic       strobe,
    output logic [2:0] bits,
    output logic       del,
    output logic       zm,
    output logic       stop,
    output logic [4:0] spare
);
    initial begin
        strobe = 1'b0;
        {bits, del, zm, stop, spare} = '0;
    end
    task automatic send_char(input logic [2:0] d, input logic dl, input logic z);
        @(posedge aclk);
        bits  <= d;
        del   <= dl;
        zm    <= z;
        spare <= 5'($urandom);
        @(posedge aclk);
        strobe <= 1'b1;
        repeat (6) @(posedge aclk);
        strobe <= 1'b0;
        // lines back to passive once the 3 us hold is over
        repeat (294) @(posedge aclk);
        {bits, del, zm} <= '0;
        repeat (700) @(posedge aclk);
    endtask
    task automatic send_stop(input logic dl);
        @(posedge aclk);
        stop <= 1'b1;
        bits <= 3'($urandom);
        del  <= dl;
        repeat (8) @(posedge aclk);
        {stop, bits, del} <= '0;
    endtask
endmodule // tape_reader_model

//--- dv/test_octal_character_load_packer.sv
// Purpose: self-checking bench for the octal character load packer
// Assumes: bready and rready held high throughout
// Notes:   expected memory writes queued by the driver, popped by the watcher
`timescale 1ns/100ps
module test_octal_character_load_packer;
    logic        aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, cnt_m;
    logic        char_bit_low, char_bit_mid, char_bit_high, delete_char_in, zero_marker_in;
    logic        stop_command_in, char_strobe_in, load_active_out, active_m;
    logic        unused_bus_bit6, unused_bus_bit8, unused_bus_bit10, unused_bus_bit11, unused_bus_bit12;
    logic [11:0] pc_m, acc_m;
    logic [23:0] expq[$];
    int          errors, total_checks;
    load_packer_pkg::mem_write_type mem_write;
    octal_character_load_packer dut (.*);
    tape_reader_model rdr (.aclk(aclk), .strobe(char_strobe_in), .bits({char_bit_high, char_bit_mid, char_bit_low}),
        .del(delete_char_in), .zm(zero_marker_in), .stop(stop_command_in),
        .spare({unused_bus_bit12, unused_bus_bit11, unused_bus_bit10, unused_bus_bit8, unused_bus_bit6}));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 200);
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
        if (n >= 200) begin
            errors++;
            final_report();
        end
    endtask
    task automatic rd(input string w, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 200);
        check({w, " rresp"}, {30'h0, s_axi_rresp}, {30'h0, er});
        if (er == load_packer_pkg::RESP_OKAY) check(w, s_axi_rdata, e);
        if (n >= 200) begin
            errors++;
            final_report();
        end
    endtask
    // model of packing, then the reader sends the character
    task automatic ch(input logic [2:0] d, input logic dl, input logic z);
        if (active_m && !dl && (d != 3'h0 || z)) begin
            acc_m = (cnt_m == 2'h0) ? {d, 9'h000} : {d, acc_m[11:3]};
            expq.push_back({pc_m, acc_m});
            if (cnt_m == 2'h3) pc_m++;
            cnt_m++;
        end
        rdr.send_char(d, dl, z);
    endtask
    always @(posedge aclk) begin
        if (mem_write.en === 1'b1) begin
            if (expq.size() == 0) check("stray write", 32'(mem_write.en), 32'h0);
            else check("mem write", {8'h0, mem_write.addr, mem_write.data}, {8'h0, expq.pop_front()});
        end
    end
    initial begin
        void'($urandom(77170));
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {clk_en, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7F;
        {active_m, cnt_m, pc_m, acc_m} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd("ctrl", 8'h00, 32'h0, 2'h0);
        rd("pc", 8'h04, 32'h0, 2'h0);
        rd("stat", 8'h08, 32'h0, 2'h0);
        rd("acc", 8'h0C, 32'h0, 2'h0);
        rd("hole", 8'h10, 32'h0, load_packer_pkg::RESP_SLVERR);
        wr(8'h14, 32'h3, load_packer_pkg::RESP_SLVERR);
        $display("registers test done");
        pc_m = 12'hFFE;
        wr(8'h04, 32'(pc_m), 2'h0);
        wr(8'h00, 32'h3, 2'h0);
        active_m = 1'b1;
        rd("stat", 8'h08, 32'h1, 2'h0);
        // characters only once loading is active
        for (int i = 1; i < 5; i++) ch(3'(i), 1'b0, 1'b0);
        wr(8'h04, 32'h123, 2'h0);
        ch(3'h0, 1'b0, 1'b1);
        ch(3'h0, 1'b0, 1'b0);
        ch(3'h7, 1'b1, 1'b1);
        for (int i = 0; i < 12; i++) ch(3'($urandom), ($urandom % 4) == 0, 1'($urandom));
        rd("pc", 8'h04, 32'(pc_m), 2'h0);
        rd("acc", 8'h0C, 32'(acc_m), 2'h0);
        rd("stat", 8'h08, {26'h0, cnt_m, 4'h1}, 2'h0);
        rdr.send_stop(1'b1);
        active_m = 1'b0;
        check("active", 32'(load_active_out), 32'h0);
        ch(3'h3, 1'b0, 1'b1);
        $display("pin stop test done");
        wr(8'h00, 32'h3, 2'h0);
        {active_m, cnt_m} = 3'h4;
        ch(3'h6, 1'b0, 1'b0);
        ch(3'h2, 1'b0, 1'b1);
        wr(8'h00, 32'h4, 2'h0);
        active_m = 1'b0;
        rd("stat", 8'h08, {26'h0, cnt_m, 4'h0}, 2'h0);
        ch(3'h1, 1'b0, 1'b1);
        rd("pc", 8'h04, 32'(pc_m), 2'h0);
        check("pending", 32'(expq.size()), 32'h0);
        $display("software stop test done");
        final_report();
    end
endmodule // test_octal_character_load_packer
